/* File: inc/mms_defines.vh */
`ifndef MMS_DEFINES_VH
`define MMS_DEFINES_VH
// =====================================================
// Timing
`define MMS_CLOCK_HZ 25000000
`define MMS_BUS_PER_BIT 256
`define MMS_ENTRY_HIGH_CYCLES 24
`define MMS_BREAK_ZERO_BITS 10
`define MMS_PRE_ECHO_BITS 2
`define MMS_CANCEL_BITS 11
`define MMS_SECURITY_BYTES 8
// =====================================================
// Commands
`define MMS_OP_READ 8'h4A
`define MMS_OP_WRITE 8'h49
`define MMS_OP_INDEXED_READ_CMD 8'h1A
`define MMS_OP_INDEXED_WRITE_CMD 8'h19
`define MMS_OP_READ_STACK_POINTER_CMD 8'h0C
`define MMS_OP_RUN 8'h28
// =====================================================
// Vectors and blank values
`define MMS_VEC_RESET_MON 16'hFEFE
`define MMS_VEC_SWI_MON 16'hFEFC
`define MMS_VEC_RESET_USR 16'hFFFE
`define MMS_VEC_SWI_USR 16'hFFFC
`define MMS_BLANK_VECTOR 16'hFFFF
`define MMS_BLANK_BYTE 8'hFF
`define MMS_SP_RETURN_OFS 16'h0001
`define MMS_SP_PCH_OFS 16'h0005
`define MMS_SP_PCL_OFS 16'h0006
`endif

/* File: rtl/mms_fifo.v */
`timescale 1ns/100ps
// =====================================================
// Receive byte FIFO, flip-flop storage
module mms_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clock_in,
  input wire reset_n_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  integer i;

  // Honest full and empty flags
  assign wr_ready_out = (count != DEPTH);
  assign rd_valid_out = (count != 0);
  assign rd_data_out = mem[rd_ptr];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;

  // Pointers and count
  always @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= wr_data_in;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

/* File: rtl/mms_uart.v */
`timescale 1ns/100ps
`include "mms_defines.vh"
// =====================================================
// Single-wire receiver: start, 8 data LSB first, stop
module mms_uart #(
  parameter BIT_CYCLES = 256
)
(
  input wire clock_in,
  input wire reset_n_in,
  input wire enable_in,
  input wire line_in,
  output reg [7:0] data_out,
  output reg valid_out,
  output reg break_out
);
  reg busy;
  reg [8:0] cnt;
  reg [3:0] bitno;
  reg [7:0] shift;
  reg allzero;

  // Mid-bit sampling; a zero stop bit with zero data marks a break
  always @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      busy <= 1'b0;
      cnt <= 9'h000;
      bitno <= 4'h0;
      shift <= 8'h00;
      allzero <= 1'b0;
      data_out <= 8'h00;
      valid_out <= 1'b0;
      break_out <= 1'b0;
    end
    else
    begin
      valid_out <= 1'b0;
      break_out <= 1'b0;
      if (!busy)
      begin
        if (enable_in && !line_in)
        begin
          busy <= 1'b1;
          cnt <= BIT_CYCLES[8:0] / 9'h002;
          bitno <= 4'h0;
          allzero <= 1'b1;
        end
      end
      else if (cnt != 9'h000)
        cnt <= cnt - 1'b1;
      else
      begin
        cnt <= BIT_CYCLES[8:0] - 1'b1;
        bitno <= bitno + 1'b1;
        if (bitno == 4'h0 && line_in)
          busy <= 1'b0;                     // False start
        else if (bitno >= 4'h1 && bitno <= 4'h8)
        begin
          shift <= {line_in, shift[7:1]};
          if (line_in)
            allzero <= 1'b0;
        end
        else if (bitno == 4'h9)
        begin
          if (line_in)
          begin
            busy <= 1'b0;
            data_out <= shift;
            valid_out <= 1'b1;
          end
          else if (!allzero)
            busy <= 1'b0;                   // Framing error, dropped
        end
        else if (bitno == 4'hA)
        begin
          // Wait for the line to recover before reporting a break
          if (line_in)
          begin
            busy <= 1'b0;
            break_out <= allzero;
          end
          else
            bitno <= 4'hA;
        end
      end
    end
  end
endmodule

/* File: rtl/mms_monitor.v */
`timescale 1ns/100ps
`include "mms_defines.vh"
module mms_monitor #(
  parameter BIT_CYCLES = `MMS_BUS_PER_BIT,
  parameter FIFO_DEPTH = 16
)
(
  input wire clock_in,
  input wire reset_n_in,
  input wire pin_reset_n_in,
  input wire irq_test_high_voltage_in,
  input wire irq_level_in,
  input wire rst_test_high_voltage_in,
  input wire mode_select_pin_a_in,
  input wire mode_select_pin_b_in,
  input wire clock_divide_select_pin_in,
  input wire [15:0] reset_vector_in,
  input wire [7:0] clock_trim_value_in,
  input wire serial_comm_pin_in,
  output reg serial_comm_pin_out,
  output reg serial_comm_pin_oe_out,
  output reg monitor_mode_out,
  output reg forced_mode_out,
  output reg use_internal_clock_out,
  output reg [7:0] trim_out,
  output reg bus_div4_out,
  output reg osc_bypass_out,
  output reg watchdog_disable_out,
  output reg extra_reset_out,
  output reg [15:0] reset_vec_addr_out,
  output reg [15:0] swi_vec_addr_out,
  output reg mem_rd_out,
  output reg mem_wr_out,
  output reg [15:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  input wire [7:0] mem_rdata_in,
  input wire [15:0] stack_pointer_in,
  output reg cpu_run_out
);
  // =====================================================
  // Reset release and mode capture
  localparam S_ENTRY = 4'h0;
  localparam S_SEC = 4'h1;
  localparam S_CMD = 4'h2;
  localparam S_GAP = 4'h3;
  localparam S_TX = 4'h4;
  localparam S_AFTER = 4'h5;
  localparam S_MEM = 4'h6;
  localparam S_CANCEL = 4'h7;
  localparam S_BRK = 4'h8;
  localparam S_IDLE = 4'h9;

  reg rst_s1;
  reg rst_s2;
  wire rst_n;
  reg captured;
  reg [4:0] entry_cnt;
  reg [3:0] state;
  reg [3:0] after_gap;
  reg [3:0] after_tx;
  reg [15:0] bit_cnt;
  reg [3:0] bits_left;
  reg [9:0] tx_shift;
  reg [3:0] sec_cnt;
  reg [7:0] opcode;
  reg [2:0] nbytes;
  reg [7:0] arg0;
  reg [7:0] arg1;
  reg [7:0] arg2;
  reg [15:0] index;
  reg [7:0] tx_byte;
  reg tx_brk;
  wire [31:0] gap_full;
  wire [31:0] cancel_full;
  wire [31:0] bit_last_full;
  wire [15:0] sp_plus_one;
  wire rx_enable;
  reg ret_pending;
  reg [1:0] ret_cnt;
  wire [7:0] rx_data;
  wire rx_valid;
  wire rx_break;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_wr_ready;
  reg fifo_pop;
  wire blank;

  assign rst_n = rst_s2;
  assign blank = (reset_vector_in == `MMS_BLANK_VECTOR);
  // Full-width counts, cut to the 16-bit timer where used
  assign gap_full = `MMS_PRE_ECHO_BITS * BIT_CYCLES;
  assign cancel_full = `MMS_CANCEL_BITS * BIT_CYCLES;
  assign bit_last_full = BIT_CYCLES - 1;
  assign sp_plus_one = stack_pointer_in + `MMS_SP_RETURN_OFS;
  // Half duplex: our own frames on the shared wire must not be taken in
  assign rx_enable = fifo_wr_ready && !serial_comm_pin_oe_out &&
    (state == S_SEC || state == S_CMD || state == S_CANCEL);

  // Two-flop release of the asynchronous reset
  always @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // =====================================================
  // Receiver and byte FIFO; receiver halts while the FIFO is full
  mms_uart #(.BIT_CYCLES(BIT_CYCLES)) mms_uart_inst (
    .clock_in(clock_in),
    .reset_n_in(rst_n),
    .enable_in(rx_enable),
    .line_in(serial_comm_pin_in),
    .data_out(rx_data),
    .valid_out(rx_valid),
    .break_out(rx_break)
  );

  mms_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) mms_fifo_inst (
    .clock_in(clock_in),
    .reset_n_in(rst_n),
    .wr_data_in(rx_data),
    .wr_valid_in(rx_valid),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // =====================================================
  // Mode capture; taken after release, and again after a pin reset ends a standard session.
  // The external reset pin does not restart a blank-vector session.
  always @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      captured <= 1'b0;
      monitor_mode_out <= 1'b0;
      forced_mode_out <= 1'b0;
      use_internal_clock_out <= 1'b0;
      trim_out <= 8'h00;
      bus_div4_out <= 1'b0;
      osc_bypass_out <= 1'b0;
      extra_reset_out <= 1'b0;
      reset_vec_addr_out <= `MMS_VEC_RESET_USR;
      swi_vec_addr_out <= `MMS_VEC_SWI_USR;
      watchdog_disable_out <= 1'b0;
    end
    else
    begin
      extra_reset_out <= 1'b0;
      if (!captured && pin_reset_n_in)
      begin
        captured <= 1'b1;
        if (irq_test_high_voltage_in && serial_comm_pin_in)
        begin
          monitor_mode_out <= 1'b1;
          bus_div4_out <= clock_divide_select_pin_in;
          osc_bypass_out <= !clock_divide_select_pin_in;
          reset_vec_addr_out <= `MMS_VEC_RESET_MON;
          swi_vec_addr_out <= `MMS_VEC_SWI_MON;
        end
        else if (blank && serial_comm_pin_in)
        begin
          monitor_mode_out <= 1'b1;
          forced_mode_out <= 1'b1;
          bus_div4_out <= 1'b1;
          use_internal_clock_out <= !irq_level_in;
          trim_out <= clock_trim_value_in;
          extra_reset_out <= 1'b1;
          reset_vec_addr_out <= `MMS_VEC_RESET_MON;
          swi_vec_addr_out <= `MMS_VEC_SWI_MON;
        end
      end
      // Standard entry: watchdog off only while test voltage persists
      if (forced_mode_out)
        watchdog_disable_out <= 1'b1;
      else
        watchdog_disable_out <= monitor_mode_out &&
          (irq_test_high_voltage_in || rst_test_high_voltage_in);
      // A pin reset leaves a standard session, never a forced one
      if (!pin_reset_n_in && monitor_mode_out && !forced_mode_out)
      begin
        captured <= 1'b0;
        monitor_mode_out <= 1'b0;
      end
    end
  end

  // =====================================================
  // Command sequencer with transmitter
  always @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_ENTRY;
      after_gap <= S_CMD;
      after_tx <= S_CMD;
      entry_cnt <= 5'h00;
      bit_cnt <= 16'h0000;
      bits_left <= 4'h0;
      tx_shift <= 10'h3FF;
      sec_cnt <= 4'h0;
      opcode <= 8'h00;
      nbytes <= 3'h0;
      arg0 <= 8'h00;
      arg1 <= 8'h00;
      index <= 16'h0000;
      tx_byte <= 8'h00;
      tx_brk <= 1'b0;
      arg2 <= 8'h00;
      ret_pending <= 1'b0;
      ret_cnt <= 2'h0;
      fifo_pop <= 1'b0;
      serial_comm_pin_out <= 1'b1;
      serial_comm_pin_oe_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 8'h00;
      cpu_run_out <= 1'b0;
    end
    else
    begin
      fifo_pop <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      cpu_run_out <= 1'b0;
      if (bit_cnt != 16'h0000)
        bit_cnt <= bit_cnt - 1'b1;
      case (state)
        S_ENTRY:
        begin
          // Host keeps the line high through the entry window
          if (!serial_comm_pin_in)
            entry_cnt <= 5'h00;
          else if (monitor_mode_out && entry_cnt != `MMS_ENTRY_HIGH_CYCLES)
            entry_cnt <= entry_cnt + 1'b1;
          else if (monitor_mode_out)
            state <= S_SEC;
        end
        S_SEC:
        begin
          // Security bytes are echoed; then a pause and the ready break
          if (sec_cnt == `MMS_SECURITY_BYTES)
          begin
            tx_brk <= 1'b1;
            after_gap <= S_CMD;
            bit_cnt <= gap_full[15:0];
            state <= S_GAP;
          end
          else if (fifo_valid && !fifo_pop)
          begin
            fifo_pop <= 1'b1;
            tx_byte <= fifo_data;
            tx_brk <= 1'b0;
            sec_cnt <= sec_cnt + 1'b1;
            after_gap <= S_SEC;
            bit_cnt <= gap_full[15:0];
            state <= S_GAP;
          end
        end
        S_CMD, S_CANCEL:
        begin
          if (rx_break)
          begin
            nbytes <= 3'h0;
            bit_cnt <= gap_full[15:0];
            state <= S_BRK;
          end
          else if (state == S_CANCEL && bit_cnt == 16'h0000)
            state <= S_MEM;
          else if (state == S_CMD && fifo_valid && !fifo_pop)
          begin
            fifo_pop <= 1'b1;
            tx_byte <= fifo_data;
            tx_brk <= 1'b0;
            if (nbytes == 3'h0)
              opcode <= fifo_data;
            else if (nbytes == 3'h1)
              arg0 <= fifo_data;
            else if (nbytes == 3'h2)
              arg1 <= fifo_data;
            else
              arg2 <= fifo_data;
            nbytes <= nbytes + 1'b1;
            after_gap <= S_AFTER;
            bit_cnt <= gap_full[15:0];
            state <= S_GAP;
          end
        end
        S_BRK:
        begin
          // Line held high two bit times, then the break goes back
          serial_comm_pin_oe_out <= 1'b1;
          serial_comm_pin_out <= 1'b1;
          if (bit_cnt == 16'h0000)
          begin
            tx_brk <= 1'b1;
            after_tx <= S_CMD;
            bits_left <= 4'h0;
            state <= S_TX;
          end
        end
        S_GAP:
        begin
          if (bit_cnt == 16'h0000)
          begin
            bits_left <= 4'h0;
            state <= S_TX;
            after_tx <= after_gap;
          end
        end
        S_TX:
        begin
          // NRZ frame out, start low and stop high; a break frame sends all ten bits low
          if (bits_left == 4'h0)
          begin
            tx_shift <= tx_brk ? 10'h000 : {1'b1, tx_byte, 1'b0};
            bits_left <= 4'hA;
            bit_cnt <= bit_last_full[15:0];
            serial_comm_pin_oe_out <= 1'b1;
            serial_comm_pin_out <= 1'b0;
          end
          else if (bit_cnt == 16'h0000)
          begin
            if (bits_left == 4'h1)
            begin
              serial_comm_pin_out <= 1'b1;
              serial_comm_pin_oe_out <= 1'b0;
              state <= after_tx;
              bits_left <= 4'h0;
            end
            else
            begin
              tx_shift <= {1'b1, tx_shift[9:1]};
              serial_comm_pin_out <= tx_shift[1];
              bits_left <= bits_left - 1'b1;
              bit_cnt <= bit_last_full[15:0];
            end
          end
        end
        S_AFTER:
        begin
          // Echo sent: is the command complete?
          if (ret_pending)
          begin
            ret_pending <= 1'b0;
            nbytes <= 3'h0;
            state <= S_CMD;
          end
          else if ((opcode == `MMS_OP_READ && nbytes == 3'h3) ||
                   (opcode == `MMS_OP_WRITE && nbytes == 3'h4) ||
                   (opcode == `MMS_OP_INDEXED_WRITE_CMD && nbytes == 3'h2) ||
                   opcode == `MMS_OP_INDEXED_READ_CMD || opcode == `MMS_OP_READ_STACK_POINTER_CMD ||
                   opcode == `MMS_OP_RUN)
          begin
            bit_cnt <= cancel_full[15:0];
            state <= S_CANCEL;
          end
          else if (opcode != `MMS_OP_READ && opcode != `MMS_OP_WRITE &&
                   opcode != `MMS_OP_INDEXED_WRITE_CMD)
          begin
            nbytes <= 3'h0;
            state <= S_CMD;
          end
          else
            state <= S_CMD;
        end
        S_MEM:
        begin
          ret_cnt <= ret_cnt + 1'b1;
          if (opcode == `MMS_OP_READ)
          begin
            mem_addr_out <= {arg0, arg1};
            mem_rd_out <= (ret_cnt == 2'h0);
            index <= {arg0, arg1};
          end
          else if (opcode == `MMS_OP_WRITE && ret_cnt == 2'h0)
          begin
            mem_addr_out <= {arg0, arg1};
            mem_wdata_out <= arg2;
            mem_wr_out <= 1'b1;
            index <= {arg0, arg1};
          end
          else if (opcode == `MMS_OP_INDEXED_WRITE_CMD && ret_cnt == 2'h0)
          begin
            mem_addr_out <= index + 16'h0001;
            mem_wdata_out <= arg0;
            mem_wr_out <= 1'b1;
            index <= index + 16'h0001;
          end
          else if (opcode == `MMS_OP_INDEXED_READ_CMD && ret_cnt == 2'h0)
          begin
            mem_addr_out <= index + 16'h0001;
            mem_rd_out <= 1'b1;
            index <= index + 16'h0001;
          end
          else if (opcode == `MMS_OP_RUN && ret_cnt == 2'h0)
            cpu_run_out <= 1'b1;
          if (ret_cnt == 2'h2)
          begin
            ret_cnt <= 2'h0;
            nbytes <= 3'h0;
            if (opcode == `MMS_OP_READ || opcode == `MMS_OP_INDEXED_READ_CMD ||
                opcode == `MMS_OP_READ_STACK_POINTER_CMD)
            begin
              tx_byte <= (opcode == `MMS_OP_READ_STACK_POINTER_CMD) ?
                sp_plus_one[7:0] : mem_rdata_in;
              tx_brk <= 1'b0;
              ret_pending <= 1'b1;
              after_gap <= S_AFTER;
              bit_cnt <= gap_full[15:0];
              state <= S_GAP;
            end
            else if (opcode == `MMS_OP_RUN)
              state <= S_IDLE;
            else
              state <= S_CMD;
          end
        end
        S_IDLE:
          state <= S_IDLE;
        default:
          state <= S_CMD;
      endcase
    end
  end
endmodule

/* File: testbench/mms_monitor_properties.sv */
`timescale 1ns/100ps
// ====================
// Port checker for the monitor block
module mms_monitor_checker #(
  parameter BIT_CYCLES = 256
)
(
  input wire clock_in,
  input wire reset_n_in,
  input wire pin_reset_n_in,
  input wire irq_test_high_voltage_in,
  input wire rst_test_high_voltage_in,
  input wire clock_divide_select_pin_in,
  input wire [15:0] reset_vector_in,
  input wire [7:0] clock_trim_value_in,
  input wire serial_comm_pin_out,
  input wire serial_comm_pin_oe_out,
  input wire monitor_mode_out,
  input wire forced_mode_out,
  input wire use_internal_clock_out,
  input wire [7:0] trim_out,
  input wire bus_div4_out,
  input wire osc_bypass_out,
  input wire watchdog_disable_out,
  input wire extra_reset_out,
  input wire [15:0] reset_vec_addr_out,
  input wire [15:0] swi_vec_addr_out
);
  default clocking dclk @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  reg [15:0] run;
  // Length of each driven low stretch; ends must fall on whole bits
  always @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      run <= 16'h0000;
    else if (serial_comm_pin_oe_out && !serial_comm_pin_out)
      run <= run + 16'h0001;
    else
      run <= 16'h0000;
  end
  // Repetitions allow a couple of cycles of lag between mode and outputs
  mon_vectors_a: assert property ((monitor_mode_out)[*3] |->
    reset_vec_addr_out == 16'hFEFE && swi_vec_addr_out == 16'hFEFC)
    else $error("monitor vectors not on FE page");
  forced_wdog_a: assert property ((forced_mode_out)[*2] |-> watchdog_disable_out)
    else $error("watchdog running in forced mode");
  forced_blank_a: assert property (forced_mode_out |-> reset_vector_in == 16'hFFFF)
    else $error("forced mode with programmed vector");
  trim_used_a: assert property ((forced_mode_out && use_internal_clock_out)[*2] |->
    trim_out == clock_trim_value_in)
    else $error("trim not passed to clock generator");
  bypass_only_a: assert property (osc_bypass_out |->
    monitor_mode_out && !forced_mode_out && !clock_divide_select_pin_in)
    else $error("divider bypass outside test voltage entry");
  div_four_a: assert property ((monitor_mode_out && !forced_mode_out &&
    clock_divide_select_pin_in)[*3] |-> bus_div4_out)
    else $error("divide by four not selected");
  tv_wdog_a: assert property ((monitor_mode_out && !forced_mode_out &&
    (irq_test_high_voltage_in || rst_test_high_voltage_in))[*2] |-> watchdog_disable_out)
    else $error("watchdog running under test voltage");
  extra_pulse_a: assert property (extra_reset_out |->
    reset_vector_in == 16'hFFFF ##1 !extra_reset_out)
    else $error("extra reset pulse wrong");
  pin_keep_a: assert property (forced_mode_out && !pin_reset_n_in |=>
    monitor_mode_out && forced_mode_out)
    else $error("reset pin left forced monitor mode");
  bit_len_a: assert property (serial_comm_pin_oe_out && serial_comm_pin_out && run != 0 |->
    run % BIT_CYCLES == 0)
    else $error("low stretch not whole bit times");
endmodule

bind mms_monitor mms_monitor_checker #(.BIT_CYCLES(BIT_CYCLES)) mms_monitor_checker_inst (
  .clock_in, .reset_n_in, .pin_reset_n_in, .irq_test_high_voltage_in,
  .rst_test_high_voltage_in, .clock_divide_select_pin_in, .reset_vector_in,
  .clock_trim_value_in, .serial_comm_pin_out, .serial_comm_pin_oe_out, .monitor_mode_out,
  .forced_mode_out, .use_internal_clock_out, .trim_out, .bus_div4_out, .osc_bypass_out,
  .watchdog_disable_out, .extra_reset_out, .reset_vec_addr_out, .swi_vec_addr_out
);

/* File: testbench/mms_host_model.sv */
`timescale 1ns/100ps
// ====================
// Host on the single wire: pulls low or lets the pull-up win
module mms_host_model #(
  parameter BIT_CYCLES = 16
)
(
  input wire clock_in,
  input wire line_in,
  output reg line_low_out
);
  initial line_low_out = 1'b0;
  // One frame, start low, data LSB first, stop high
  task send_byte(input [7:0] b);
    integer i;
    reg [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1)
      begin
        @(negedge clock_in);
        line_low_out = !f[i];
        repeat (BIT_CYCLES - 1) @(negedge clock_in);
      end
    end
  endtask
  // Bounded wait for a start, mid-bit sampling of ten bits
  task recv_frame(output [9:0] f, output ok);
    integer n;
    begin
      n = 0;
      ok = 1'b0;
      f = 10'h3FF;
      while (line_in && n < 40 * BIT_CYCLES)
      begin
        @(negedge clock_in);
        n = n + 1;
      end
      if (!line_in)
      begin
        ok = 1'b1;
        repeat (BIT_CYCLES / 2) @(negedge clock_in);
        for (n = 0; n < 10; n = n + 1)
        begin
          f[n] = line_in;
          repeat (BIT_CYCLES) @(negedge clock_in);
        end
        repeat (BIT_CYCLES / 2) @(negedge clock_in);
      end
    end
  endtask
endmodule

/* File: testbench/mms_monitor_tb_top.sv */
`timescale 1ns/100ps
// ====================
// Bench: entry modes, then serial traffic in forced mode
module mms_monitor_tb_top;
  localparam BIT = 16;
  reg clock_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg pin_reset_n_in = 1'b1;
  reg irq_test_high_voltage_in = 1'b0;
  reg irq_level_in = 1'b0;
  reg clock_divide_select_pin_in = 1'b0;
  reg [15:0] reset_vector_in = 16'hFFFF;
  reg [7:0] clock_trim_value_in = 8'h5C;
  reg [7:0] mem_rdata_in = 8'h00;
  reg [15:0] wa, wd, ra;
  wire serial_comm_pin_out, serial_comm_pin_oe_out, monitor_mode_out, forced_mode_out;
  wire use_internal_clock_out, bus_div4_out, osc_bypass_out, watchdog_disable_out;
  wire extra_reset_out, mem_rd_out, mem_wr_out, cpu_run_out, host_low;
  wire [7:0] trim_out, mem_wdata_out;
  wire [15:0] reset_vec_addr_out, swi_vec_addr_out, mem_addr_out;
  // Open-drain wire: low if anyone pulls low, pull-up otherwise
  wire line = !((serial_comm_pin_oe_out && !serial_comm_pin_out) || host_low);
  integer errors = 0;
  integer n_compared = 0;
  integer cycles = 0;

  mms_monitor #(.BIT_CYCLES(BIT), .FIFO_DEPTH(16)) mms_monitor_inst (
    .clock_in, .reset_n_in, .pin_reset_n_in, .irq_test_high_voltage_in, .irq_level_in,
    .rst_test_high_voltage_in(1'b0), .mode_select_pin_a_in(1'b0),
    .mode_select_pin_b_in(1'b0), .clock_divide_select_pin_in, .reset_vector_in,
    .clock_trim_value_in, .serial_comm_pin_in(line), .serial_comm_pin_out,
    .serial_comm_pin_oe_out, .monitor_mode_out, .forced_mode_out, .use_internal_clock_out,
    .trim_out, .bus_div4_out, .osc_bypass_out, .watchdog_disable_out, .extra_reset_out,
    .reset_vec_addr_out, .swi_vec_addr_out, .mem_rd_out, .mem_wr_out, .mem_addr_out,
    .mem_wdata_out, .mem_rdata_in, .stack_pointer_in(16'h00F0), .cpu_run_out
  );
  mms_host_model #(.BIT_CYCLES(BIT)) mms_host_model_inst (
    .clock_in(clock_in), .line_in(line), .line_low_out(host_low)
  );

  always #20 clock_in = !clock_in;
  // Memory stand-in: data is the low address byte mixed with a constant
  always @(negedge clock_in)
    mem_rdata_in <= mem_addr_out[7:0] ^ 8'hA5;
  // Capture bus strobes for later comparison
  always @(posedge clock_in)
  begin
    if (mem_wr_out)
    begin
      wa <= mem_addr_out;
      wd <= {8'h00, mem_wdata_out};
    end
    if (mem_rd_out)
      ra <= mem_addr_out;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock_in)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      errors = errors + 1;
      results;
    end
  end

  task check(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Power-on reset with new pin levels, held 12 cycles
  task enter(input tv, input lvl, input div, input [15:0] v);
    begin
      @(negedge clock_in);
      reset_n_in = 1'b0;
      irq_test_high_voltage_in = tv;
      irq_level_in = lvl;
      clock_divide_select_pin_in = div;
      reset_vector_in = v;
      repeat (12) @(negedge clock_in);
      reset_n_in = 1'b1;
      repeat (6) @(negedge clock_in);
    end
  endtask
  // Send a byte and expect its echo as a clean frame
  task xfer(input [7:0] b);
    reg [9:0] f;
    reg ok;
    begin
      mms_host_model_inst.send_byte(b);
      mms_host_model_inst.recv_frame(f, ok);
      check({5'h00, ok, f}, {5'h00, 1'b1, 1'b1, b, 1'b0});
    end
  endtask

  task test_tv_entry;
    integer d;
    begin
      for (d = 0; d < 2; d = d + 1)
      begin
        enter(1'b1, 1'b1, d[0], 16'h1234);
        check(forced_mode_out, 16'h0000);
        check(bus_div4_out, d[0]);
        check(osc_bypass_out, !d[0]);
        check(watchdog_disable_out, 16'h0001);
        check(reset_vec_addr_out, 16'hFEFE);
      end
      $display("tv entry done");
    end
  endtask
  task test_user_entry;
    begin
      enter(1'b0, 1'b1, 1'b0, 16'h1234);
      check(monitor_mode_out, 16'h0000);
      check(reset_vec_addr_out, 16'hFFFE);
      check(swi_vec_addr_out, 16'hFFFC);
      $display("user entry done");
    end
  endtask
  task test_forced_entry;
    integer l;
    begin
      for (l = 1; l >= 0; l = l - 1)
      begin
        enter(1'b0, l[0], 1'b1, 16'hFFFF);
        check(forced_mode_out, 16'h0001);
        check(use_internal_clock_out, !l[0]);
        check(watchdog_disable_out, 16'h0001);
        check(swi_vec_addr_out, 16'hFEFC);
      end
      check(trim_out, clock_trim_value_in);
      $display("forced entry done");
    end
  endtask
  // Security bytes, ready break, one read, one write, an indexed read and a stack pointer read, then reset pin
  task test_serial;
    integer i;
    reg [9:0] f;
    reg ok;
    begin
      repeat (24) @(negedge clock_in);
      for (i = 0; i < 8; i = i + 1)
        xfer(8'h10 + i[7:0]);
      mms_host_model_inst.recv_frame(f, ok);
      check({5'h00, ok, f}, 16'h0400);
      xfer(8'h4A);
      xfer(8'h12);
      xfer(8'h34);
      mms_host_model_inst.recv_frame(f, ok);
      check({5'h00, ok, f}, {5'h00, 1'b1, 1'b1, 8'h91, 1'b0});
      check(ra, 16'h1234);
      repeat (12 * BIT) @(negedge clock_in);
      xfer(8'h49);
      xfer(8'h12);
      xfer(8'h35);
      xfer(8'h5A);
      repeat (12 * BIT) @(negedge clock_in);
      check(wa, 16'h1235);
      check(wd, 16'h005A);
      xfer(8'h1A);
      mms_host_model_inst.recv_frame(f, ok);
      check({5'h00, ok, f}, {5'h00, 1'b1, 1'b1, 8'h93, 1'b0});
      check(ra, 16'h1236);
      xfer(8'h0C);
      mms_host_model_inst.recv_frame(f, ok);
      check({5'h00, ok, f}, {5'h00, 1'b1, 1'b1, 8'hF1, 1'b0});
      pin_reset_n_in = 1'b0;
      repeat (4) @(negedge clock_in);
      pin_reset_n_in = 1'b1;
      repeat (4) @(negedge clock_in);
      check(monitor_mode_out, 16'h0001);
      $display("serial done");
    end
  endtask

  initial
  begin
    test_tv_entry;
    test_user_entry;
    test_forced_entry;
    test_serial;
    results;
  end
endmodule
